// >>> hdl/t1aes_filt_if.sv
// Interface between the status block and one persistence filter.
`timescale 1ns/1ps
`default_nettype none
interface t1aes_filt_if;
    logic clk;     // Framer clock.
    logic rst_n;   // Synchronised reset, active low.
    logic ce;      // Clock enable.
    logic cond;    // Raw condition from the framer.
    logic state;   // Filtered defect state.
    logic change;  // High in the cycle the state is about to toggle.

    modport filt (input clk, input rst_n, input ce, input cond,
                  output state, output change);
    modport ctl  (output clk, output rst_n, output ce, output cond,
                  input state, input change);
endinterface
`default_nettype wire

// >>> hdl/t1aes_persist.sv
// Persistence filter that declares and clears a defect after set times.
`timescale 1ns/1ps
`default_nettype none
module t1aes_persist #(
    parameter int DECL_CYC = 4,   // Cycles the condition must persist.
    parameter int CLR_CYC  = 4,   // Cycles it must be absent; 0 is at once.
    parameter int CNT_W    = 25   // Counter width.
) (
    t1aes_filt_if.filt f
);

    localparam logic [CNT_W-1:0] DECL_LAST = CNT_W'(DECL_CYC - 1);
    localparam logic [CNT_W-1:0] CLR_LAST  =
        CNT_W'((CLR_CYC == 0) ? 0 : CLR_CYC - 1);
    localparam logic CLR_NOW = (CLR_CYC == 0);

    t1aes_pkg::t1aes_state_e state;       // Current filter state.
    t1aes_pkg::t1aes_state_e next_state;  // State for the next edge.
    logic [CNT_W-1:0]        cnt;         // Length of the current run.
    logic [CNT_W-1:0]        next_cnt;    // Run length for the next edge.

    // Any break in the run restarts the count, so only an unbroken
    // stretch of the condition, or of its absence, moves the state.
    always_comb begin
        next_state = state;
        next_cnt   = '0;
        case (state)
            t1aes_pkg::T1AES_IDLE: begin
                if (f.cond) begin
                    if (cnt == DECL_LAST) begin
                        next_state = t1aes_pkg::T1AES_ACTIVE;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end
            t1aes_pkg::T1AES_ACTIVE: begin
                if (!f.cond) begin
                    if (CLR_NOW || cnt == CLR_LAST) begin
                        next_state = t1aes_pkg::T1AES_IDLE;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_state = t1aes_pkg::T1AES_IDLE;
            end
        endcase
    end

    // State and counter registers, frozen while the clock enable is low.
    always_ff @(posedge f.clk or negedge f.rst_n) begin
        if (!f.rst_n) begin
            state <= t1aes_pkg::T1AES_IDLE;
            cnt   <= '0;
        end else if (f.ce) begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign f.state  = (state == t1aes_pkg::T1AES_ACTIVE);
    assign f.change = f.ce && (next_state != state);

    default clocking cb @(posedge f.clk); endclocking
    default disable iff (!f.rst_n);

    a_declare_after_run: assert property (
        $rose(f.state) |-> $past(cnt) == DECL_LAST && $past(f.cond))
        else $error("Defect declared before its persistence time.");
    a_clear_after_run: assert property (
        $fell(f.state) |-> !$past(f.cond)
                           && (CLR_NOW || $past(cnt) == CLR_LAST))
        else $error("Defect cleared at the wrong time.");

endmodule
`default_nettype wire

// >>> hdl/t1aes_pkg.sv
// Package of constants and types for the T1 receive alarm status block.
package t1aes_pkg;

    // Register addresses, with the channel nibble held at zero.
    localparam logic [15:0] ADDR_BLOCK_EN  = 16'h0B01;
    localparam logic [15:0] ADDR_STATUS    = 16'h0B02;
    localparam logic [15:0] ADDR_EVENT_EN  = 16'h0B03;

    // Bit positions inside the status register.
    localparam int BIT_FRAME_LOSS    = 7;
    localparam int BIT_ALARM_IND     = 6;
    localparam int BIT_REMOTE_ALARM  = 5;
    localparam int BIT_SIGNAL_LOSS   = 4;

    // Bit position of the alarm group enable in the block enable register.
    localparam int BIT_ALARM_GROUP   = 1;

    // Reset values of the registers.
    localparam logic [7:0] STATUS_RST   = 8'h00;
    localparam logic [3:0] EVENT_EN_RST = 4'h0;
    localparam logic       GROUP_EN_RST = 1'b0;

    // Clock rate and persistence times.
    localparam int SYS_CLK_HZ     = 20_000_000;
    localparam int AIS_TIME_MS    = 42;
    localparam int RAI_TIME_MS    = 900;
    localparam int AIS_CYCLES     = AIS_TIME_MS * (SYS_CLK_HZ / 1000);
    localparam int RAI_CYCLES     = RAI_TIME_MS * (SYS_CLK_HZ / 1000);

    // Loss of signal: run length in bits and the one-in-eight density.
    localparam int LOS_BITS        = 175;
    localparam int LOS_DENSITY_DIV = 8;
    localparam logic [7:0] LOS_RUN_LAST = 8'(LOS_BITS - 1);
    localparam logic [7:0] LOS_ONES_MIN =
        8'((LOS_BITS + LOS_DENSITY_DIV - 1) / LOS_DENSITY_DIV);

    // One-hot states of a persistence filter.
    typedef enum logic [1:0] {
        T1AES_IDLE   = 2'b01,
        T1AES_ACTIVE = 2'b10
    } t1aes_state_e;

endpackage

// >>> hdl/t1aes_top.sv
// Receive T1 alarm and error status register with its defect logic.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bit 7 shows live out-of-frame state.
// - Declare alarm indication after 42 ms persistence.
// - Clear alarm indication after 42 ms absence.
// - Declare remote alarm after 900 ms persistence.
// - Clear remote alarm immediately when condition ends.
// - Declare signal loss after 175 lost bits.
// - Clear loss on absence or density reached.
// - Live bits 7-4 ignore host writes.
// - Bit 3 latches any line code violation.
// - Reading status clears latched bits 3-0.
// - Bit 2 latches every out-of-frame change.
// - Bit 1 latches every alarm indication change.
// - Bit 0 latches every remote alarm change.
// - Event interrupts only when individually enabled.
// - Event enable register bits 3-0, reset zero.
// - Group reaches interrupt only with block enable.
module t1aes_top #(
    parameter int AIS_CYC = t1aes_pkg::AIS_CYCLES, // Alarm indication time.
    parameter int RAI_CYC = t1aes_pkg::RAI_CYCLES, // Remote alarm time.
    parameter int CNT_W   = 25                     // Filter counter width.
) (
    input  wire logic        SYS_CLK,        // Framer clock, 20 MHz.
    input  wire logic        RST_B,          // Asynchronous reset.
    input  wire logic        CE,             // Clock enable.
    input  wire logic [15:0] ADDR,           // Register address.
    input  wire logic [7:0]  WR_DATA,        // Register write data.
    input  wire logic        WR_STB,         // Write strobe.
    input  wire logic        RD_STB,         // Read strobe.
    output logic      [7:0]  RD_DATA,        // Read data, one cycle later.
    input  wire logic        RX_DATA,        // Received line bit, a pin.
    input  wire logic        LOS_COND,       // Line loss condition, a pin.
    input  wire logic        RX_BIT_STB,     // One pulse per received bit.
    input  wire logic        LCV_EVT,        // Line code violation pulse.
    input  wire logic        FRAME_BIT_STB,  // One pulse per framing bit.
    input  wire logic        FRAME_BIT_ERR,  // Framing bit was wrong.
    input  wire logic        REFRAME_DONE,   // Framer regained alignment.
    input  wire logic [3:0]  FRAME_ERR_TOL,  // Frame error tolerance.
    input  wire logic [3:0]  FRAME_ERR_WIN,  // Frame error window.
    input  wire logic        AIS_COND,       // Alarm indication condition.
    input  wire logic        RAI_COND,       // Remote alarm condition.
    output logic             IRQ_REQ         // Alarm group interrupt.
);

    // A zero tolerance or window would never make sense, so it acts as one.
    function automatic logic [3:0] t1aes_at_least_one(input logic [3:0] v);
        t1aes_at_least_one = (v == 4'h0) ? 4'h1 : v;
    endfunction

    // Address decode shared by reads and writes.
    function automatic logic t1aes_hit(input logic [15:0] a,
                                       input logic [15:0] off);
        t1aes_hit = (a == off);
    endfunction

    logic rst_m;   // Reset synchroniser, first stage.
    logic rst_n;   // Reset synchroniser, released copy.

    // Reset asserts at once and releases through two flip-flops, so no
    // register leaves reset on a clock edge near the release.
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    logic rx_data_m;   // Line bit synchroniser, first stage.
    logic rx_data_s;   // Line bit, synchronised.
    logic los_cond_m;  // Loss condition synchroniser, first stage.
    logic los_cond_s;  // Loss condition, synchronised.

    // Both pins come from the line side and are not timed to our clock.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_m  <= 1'b0;
            rx_data_s  <= 1'b0;
            los_cond_m <= 1'b0;
            los_cond_s <= 1'b0;
        end else if (CE) begin
            rx_data_m  <= RX_DATA;
            rx_data_s  <= rx_data_m;
            los_cond_m <= LOS_COND;
            los_cond_s <= los_cond_m;
        end
    end

    // Register decode. All sixteen address bits take part, so the
    // channel nibble must be zero.
    wire hit_status   = t1aes_hit(ADDR, t1aes_pkg::ADDR_STATUS);
    wire hit_block_en = t1aes_hit(ADDR, t1aes_pkg::ADDR_BLOCK_EN);
    wire hit_event_en = t1aes_hit(ADDR, t1aes_pkg::ADDR_EVENT_EN);
    wire rd_status    = RD_STB && hit_status;
    wire wr_block_en  = WR_STB && hit_block_en;
    wire wr_event_en  = WR_STB && hit_event_en;
    wire any_hit      = hit_status || hit_block_en || hit_event_en;

    // Out-of-frame detection.
    logic       frame_loss_state;  // Out-of-frame currently declared.
    logic [3:0] err_cnt;           // Framing errors in the current window.
    logic [3:0] win_cnt;           // Framing bits seen in the window.

    wire [3:0] eff_tol  = t1aes_at_least_one(FRAME_ERR_TOL);
    wire [3:0] eff_win  = t1aes_at_least_one(FRAME_ERR_WIN);
    wire [4:0] err_sum  = {1'b0, err_cnt} + {4'h0, FRAME_BIT_ERR};
    wire       win_end  = (win_cnt == (eff_win - 4'h1));
    wire       oof_set  = FRAME_BIT_STB && FRAME_BIT_ERR
                          && (err_sum >= {1'b0, eff_tol});
    // Once declared, only the framer's own realignment ends the defect.
    wire next_frame_loss = frame_loss_state ? !REFRAME_DONE : oof_set;
    // High for one cycle at each out-of-frame edge.
    wire oof_change      = CE && (next_frame_loss != frame_loss_state);

    // The window restarts after its last framing bit; errors from the
    // previous window do not carry over, which trades a little
    // sensitivity at window edges for a very small counter.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            frame_loss_state <= 1'b0;
            err_cnt          <= 4'h0;
            win_cnt          <= 4'h0;
        end else if (CE) begin
            frame_loss_state <= next_frame_loss;
            // The window moves on framing bits only.
            if (FRAME_BIT_STB) begin
                err_cnt <= win_end ? 4'h0 : err_sum[3:0];
                win_cnt <= win_end ? 4'h0 : win_cnt + 4'h1;
            end
        end
    end

    // Alarm indication and remote alarm persistence filters.
    t1aes_filt_if ais_if ();
    t1aes_filt_if rai_if ();

    assign ais_if.clk   = SYS_CLK;
    assign ais_if.rst_n = rst_n;
    assign ais_if.ce    = CE;
    assign ais_if.cond  = AIS_COND;
    assign rai_if.clk   = SYS_CLK;
    assign rai_if.rst_n = rst_n;
    assign rai_if.ce    = CE;
    assign rai_if.cond  = RAI_COND;

    // Alarm indication uses one time both ways.
    t1aes_persist #(
        .DECL_CYC (AIS_CYC),
        .CLR_CYC  (AIS_CYC),
        .CNT_W    (CNT_W)
    ) u_ais (
        .f (ais_if.filt)
    );

    // The remote alarm clears at once, whatever signature follows it.
    t1aes_persist #(
        .DECL_CYC (RAI_CYC),
        .CLR_CYC  (0),
        .CNT_W    (CNT_W)
    ) u_rai (
        .f (rai_if.filt)
    );

    // Live defect states for the status word.
    wire alarm_indication_state = ais_if.state;
    wire remote_alarm_state     = rai_if.state;

    // Loss of signal detection, counted in received bits.
    logic       signal_loss_state; // Loss of signal currently declared.
    logic [7:0] loss_run;          // Consecutive bits with the condition.
    logic [7:0] dens_win;          // Bit position in the density window.
    logic [7:0] ones_cnt;          // Ones seen in the density window.

    // Ones are counted on the synchronised line bit.
    wire [7:0] ones_next = ones_cnt + {7'h00, rx_data_s};
    wire dens_end  = RX_BIT_STB && (dens_win == t1aes_pkg::LOS_RUN_LAST);
    wire dens_ok   = dens_end && (ones_next >= t1aes_pkg::LOS_ONES_MIN);
    wire los_set   = RX_BIT_STB && los_cond_s
                     && (loss_run == t1aes_pkg::LOS_RUN_LAST);
    wire los_clear = !los_cond_s || dens_ok;
    wire next_signal_loss = signal_loss_state ? !los_clear : los_set;

    // The density window runs all the time so that a recovering line is
    // judged on a whole window, not on a window started mid-burst.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            signal_loss_state <= 1'b0;
            loss_run          <= 8'h00;
            dens_win          <= 8'h00;
            ones_cnt          <= 8'h00;
        end else if (CE) begin
            signal_loss_state <= next_signal_loss;
            // Any gap in the condition restarts the run.
            if (!los_cond_s) begin
                loss_run <= 8'h00;
            end else if (RX_BIT_STB && !los_set) begin
                loss_run <= loss_run + 8'h01;
            end else if (los_set) begin
                loss_run <= 8'h00;
            end
            if (RX_BIT_STB) begin
                dens_win <= dens_end ? 8'h00 : dens_win + 8'h01;
                ones_cnt <= dens_end ? 8'h00 : ones_next;
            end
        end
    end

    // Latched event flags, bit 3 down to bit 0.
    logic [3:0] event_flags;      // Latched flags.
    logic [3:0] event_en;         // Per-source interrupt enables.
    logic       alarm_group_en;   // Block level enable of the group.

    // One event strobe per flag, in bit order.
    wire [3:0] events = {LCV_EVT, oof_change,
                         ais_if.change, rai_if.change};
    // A new event wins over the clearing read in the same cycle.
    wire [3:0] next_event_flags =
        (event_flags & ~{4{rd_status}}) | events;

    // Flags record every event; the enables only steer the interrupt.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            event_flags <= t1aes_pkg::STATUS_RST[3:0];
        end else if (CE) begin
            event_flags <= next_event_flags;
        end
    end

    // Enable registers; the status register takes no write at all.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            event_en       <= t1aes_pkg::EVENT_EN_RST;
            alarm_group_en <= t1aes_pkg::GROUP_EN_RST;
        end else if (CE) begin
            if (wr_event_en) begin
                event_en <= WR_DATA[3:0];
            end
            if (wr_block_en) begin
                alarm_group_en <= WR_DATA[t1aes_pkg::BIT_ALARM_GROUP];
            end
        end
    end

    // Status as software sees it: live states above, flags below.
    wire [7:0] status_word = {frame_loss_state, alarm_indication_state,
                              remote_alarm_state, signal_loss_state,
                              event_flags};
    // Only the alarm group bit is kept here.
    wire [7:0] block_word  = {6'h00, alarm_group_en, 1'b0};
    wire [7:0] event_word  = {4'h0, event_en};
    // Unmapped addresses read as zero.
    wire [7:0] rd_mux = hit_status   ? status_word :
                        hit_block_en ? block_word  :
                        hit_event_en ? event_word  : 8'h00;

    // The interrupt sees the flags as they stand after this edge,
    // so it rises with the flag behind it.
    wire next_irq = alarm_group_en
                    && (|(next_event_flags & event_en));

    // Read data stand only in the cycle after the strobe; the status
    // snapshot is taken before the clear lands.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RD_DATA <= 8'h00;
            IRQ_REQ <= 1'b0;
        end else if (CE) begin
            RD_DATA <= RD_STB ? rd_mux : 8'h00;
            IRQ_REQ <= next_irq;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);
    // No check runs while the synchronised reset is low.

    a_oof_live_read: assert property (
        CE && rd_status |=> RD_DATA[7] == $past(frame_loss_state))
        else $error("Status bit 7 does not show the out-of-frame state.");
    a_oof_change_flag: assert property (
        $changed(frame_loss_state) |-> event_flags[2])
        else $error("Out-of-frame change was not latched.");
    a_ais_change_flag: assert property (
        $changed(alarm_indication_state) |-> event_flags[1])
        else $error("Alarm indication change was not latched.");
    a_rai_change_flag: assert property (
        $changed(remote_alarm_state) |-> event_flags[0])
        else $error("Remote alarm change was not latched.");
    a_lcv_set_wins: assert property (
        CE && LCV_EVT && rd_status |=> event_flags[3])
        else $error("Line code event lost against a clearing read.");
    a_read_clears_flag: assert property (
        CE && rd_status && !LCV_EVT |=> !event_flags[3])
        else $error("Status read did not clear the line code flag.");
    a_other_read_keeps: assert property (
        CE && RD_STB && !hit_status && event_flags[3] |=> event_flags[3])
        else $error("A read of another address cleared a flag.");
    a_irq_needs_enables: assert property (
        $rose(IRQ_REQ) |-> $past(alarm_group_en) && ($past(event_en) != 4'h0))
        else $error("Interrupt raised without its enables.");
    a_los_declare_run: assert property (
        CE && los_set && !signal_loss_state |=> signal_loss_state)
        else $error("Signal loss not declared after the full run.");
    a_los_clear_absent: assert property (
        CE && signal_loss_state && !los_cond_s |=> !signal_loss_state)
        else $error("Signal loss not cleared when the condition ended.");
    a_live_ignores_write: assert property (
        CE && WR_STB && hit_status && !los_set && !los_clear
        && !oof_change |=> $stable(signal_loss_state)
                           && $stable(frame_loss_state))
        else $error("A status write changed a live bit.");

    // Register port and interrupt path.
    a_rd_data_idle: assert property (
        CE && !RD_STB |=> RD_DATA == 8'h00)
        else $error("Read data stayed up.");
    a_event_en_write: assert property (
        CE && wr_event_en |=> event_en == $past(WR_DATA[3:0]))
        else $error("Enable write lost.");
    a_irq_follows: assert property (
        CE |=> IRQ_REQ == ($past(alarm_group_en)
                           && |(event_flags & $past(event_en))))
        else $error("Interrupt does not follow flags.");
    a_unmapped_read: assert property (
        CE && RD_STB && !any_hit |=> RD_DATA == 8'h00)
        else $error("Unmapped read did not return zero.");

    // Main scenarios the bench should reach.
    c_oof_declared: cover property ($rose(frame_loss_state));
    c_ais_cleared:  cover property ($fell(alarm_indication_state));
    c_los_declared: cover property ($rose(signal_loss_state));
    c_read_clears:  cover property (rd_status && event_flags != 4'h0);
    c_irq_raised:   cover property ($rose(IRQ_REQ));

endmodule
`default_nettype wire

// >>> sim/t1aes_line_model.sv
// Behavioural model of the incoming T1 line at the receive pins.
`timescale 1ns/1ps
`default_nettype none
module t1aes_line_model (
    input  wire logic clk,        // Framer clock.
    input  wire logic lose,       // High while the far end is silent.
    output logic      rx_data,    // Received line bit.
    output logic      rx_bit_stb, // One pulse per received bit.
    output logic      los_cond    // Loss level from the line interface.
);
    logic [1:0] div; // Four framer clocks per received bit.
    logic [1:0] pat; // Pattern phase: one bit in four is a one.
    // Give every pin a value before the first clock edge.
    initial begin
        div = 2'h0;
        pat = 2'h0;
        rx_data = 1'b0;
        rx_bit_stb = 1'b0;
        los_cond = 1'b0;
    end
    // Ones density is one in four, above the one-in-eight minimum, and a
    // lost line carries only zeros, as a dead line would.
    always @(posedge clk) begin
        div <= div + 2'h1;
        rx_bit_stb <= (div == 2'h3);
        if (div == 2'h3) begin
            pat <= pat + 2'h1;
        end
        rx_data <= !lose && (pat == 2'h0);
        los_cond <= lose;
    end
endmodule
`default_nettype wire

// >>> sim/t1aes_top_tb_top.sv
// Self-checking testbench for the T1 receive alarm status block.
`timescale 1ns/1ps
`default_nettype none
module t1aes_top_tb_top;
    localparam logic [15:0] ST = t1aes_pkg::ADDR_STATUS;   // Status.
    localparam logic [15:0] EV = t1aes_pkg::ADDR_EVENT_EN; // Event enables.
    localparam logic [15:0] BK = t1aes_pkg::ADDR_BLOCK_EN; // Group enable.
    logic        clk = 1'b0;       // Framer clock, 50 ns period.
    logic        rst_b = 1'b0;     // Reset, active low.
    logic [15:0] addr = 16'h0000;  // Register address.
    logic [7:0]  wdata = 8'h00;    // Register write data.
    logic        wr = 1'b0;        // Write strobe.
    logic        rd = 1'b0;        // Read strobe.
    logic        lcv = 1'b0;       // Line code violation pulse.
    logic        fstb = 1'b0;      // Framing bit strobe.
    logic        ferr = 1'b0;      // Framing bit error.
    logic        refr = 1'b0;      // Reframe done.
    logic        ais = 1'b0;       // Alarm indication condition.
    logic        rai = 1'b0;       // Remote alarm condition.
    logic        lose = 1'b0;      // Far end goes silent.
    logic        ce = 1'b1;        // Clock enable.
    logic [3:0]  tol = 4'h2;       // Frame error tolerance.
    logic [3:0]  win = 4'h4;       // Frame error window.
    logic [7:0]  rdata;            // Read data.
    logic        irq;              // Interrupt request.
    logic        rx_data;          // Line bit from the model.
    logic        rx_stb;           // Bit strobe from the model.
    logic        los_cond;         // Loss level from the model.
    logic [3:0]  en;               // Event enables in use.
    logic        grp;              // Group enable in use.
    int          errors = 0;       // Mismatches seen.
    int          check_count = 0;  // Comparisons made.

    always #25 clk = ~clk;

    // Short persistence times keep the run brief.
    t1aes_top #(.AIS_CYC(20), .RAI_CYC(50), .CNT_W(8)) u_t1aes_top (
        .SYS_CLK(clk), .RST_B(rst_b), .CE(ce), .ADDR(addr),
        .WR_DATA(wdata), .WR_STB(wr), .RD_STB(rd), .RD_DATA(rdata),
        .RX_DATA(rx_data), .LOS_COND(los_cond), .RX_BIT_STB(rx_stb),
        .LCV_EVT(lcv), .FRAME_BIT_STB(fstb), .FRAME_BIT_ERR(ferr),
        .REFRAME_DONE(refr), .FRAME_ERR_TOL(tol), .FRAME_ERR_WIN(win),
        .AIS_COND(ais), .RAI_COND(rai), .IRQ_REQ(irq));
    t1aes_line_model u_t1aes_line_model (.clk(clk), .lose(lose),
        .rx_data(rx_data), .rx_bit_stb(rx_stb), .los_cond(los_cond));

    // Interrupt expected from enables, group enable and pending flags.
    function automatic logic exp_irq(input logic [3:0] e, input logic g,
                                     input logic [3:0] f);
        return g && ((e & f) != 4'h0);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Waits end just after an edge so that its updates have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // The read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // One-cycle pulses on the event inputs.
    task automatic evt(input logic l, input logic f, input logic e,
                       input logic r);
        @(posedge clk);
        lcv <= l;
        fstb <= f;
        ferr <= e;
        refr <= r;
        @(posedge clk);
        {lcv, fstb, ferr, refr} <= 4'h0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        $display("mismatch at %0t: run timed out", $time);
        end_of_test();
    end

    initial begin
        void'($urandom(32'hFFFD));
        tick(10);
        rst_b <= 1'b1;
        tick(5);
        rd_chk(ST, 8'h00);
        rd_chk(EV, 8'h00);
        rd_chk(BK, 8'h00);
        rd_chk(16'h0B05, 8'h00);
        wr_reg(ST, 8'hFF);
        rd_chk(ST, 8'h00);
        // A frozen block must miss this pulse.
        ce <= 1'b0;
        evt(1'b1, 1'b0, 1'b0, 1'b0);
        ce <= 1'b1;
        rd_chk(ST, 8'h00);
        // Random enables against line code violations.
        for (int i = 0; i < 8; i++) begin
            en = 4'($urandom);
            grp = 1'($urandom);
            wr_reg(EV, {4'h0, en});
            wr_reg(BK, {6'h00, grp, 1'b0});
            rd_chk(EV, {4'h0, en});
            chk({7'h00, irq}, 8'h00);
            evt(1'b1, 1'b0, 1'b0, 1'b0);
            tick(1);
            chk({7'h00, irq}, {7'h00, exp_irq(en, grp, 4'h8)});
            rd_chk(ST, 8'h08);
            rd_chk(ST, 8'h00);
        end
        wr_reg(BK, 8'h02);
        // An event in the cycle of a clearing read is kept.
        @(posedge clk);
        addr <= ST;
        rd <= 1'b1;
        lcv <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        lcv <= 1'b0;
        rd_chk(ST, 8'h08);
        evt(1'b1, 1'b0, 1'b0, 1'b0);
        rd_chk(BK, 8'h02);
        rd_chk(ST, 8'h08);
        // Alarm indication: a short burst, then declare and clear.
        ais <= 1'b1;
        tick(15);
        ais <= 1'b0;
        tick(3);
        rd_chk(ST, 8'h00);
        ais <= 1'b1;
        tick(30);
        rd_chk(ST, 8'h42);
        ais <= 1'b0;
        tick(10);
        rd_chk(ST, 8'h40);
        tick(30);
        rd_chk(ST, 8'h02);
        // Remote alarm: slow to declare, cleared at once.
        rai <= 1'b1;
        tick(40);
        rd_chk(ST, 8'h00);
        tick(15);
        rd_chk(ST, 8'h21);
        rai <= 1'b0;
        rd_chk(ST, 8'h01);
        // Out of frame: two errors within the window of four.
        evt(1'b0, 1'b1, 1'b1, 1'b0);
        evt(1'b0, 1'b1, 1'b0, 1'b0);
        rd_chk(ST, 8'h00);
        evt(1'b0, 1'b1, 1'b1, 1'b0);
        rd_chk(ST, 8'h84);
        evt(1'b0, 1'b0, 1'b0, 1'b1);
        rd_chk(ST, 8'h04);
        // Tolerance above the errors, then zero, which acts as one.
        tol <= 4'hF;
        evt(1'b0, 1'b1, 1'b1, 1'b0);
        rd_chk(ST, 8'h00);
        tol <= 4'h0;
        evt(1'b0, 1'b1, 1'b1, 1'b0);
        rd_chk(ST, 8'h84);
        evt(1'b0, 1'b0, 1'b0, 1'b1);
        rd_chk(ST, 8'h04);
        // Loss of signal at four clocks per bit.
        lose <= 1'b1;
        tick(680);
        rd_chk(ST, 8'h00);
        tick(40);
        rd_chk(ST, 8'h10);
        lose <= 1'b0;
        tick(4);
        rd_chk(ST, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
